// >>> include/bfpt_pkg.sv
package bfpt_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          CYCLE_MS        = 5;  // program cycle and delay step
    localparam int          CYCLE_CLKS      = CLK_HZ / 1000 * CYCLE_MS;
    localparam int          DLY_W           = 19;
    localparam logic [18:0] DLY_MAX         = 19'h5_7E40;  // 1800.000 s in 5 ms steps
    localparam logic [18:0] RETRIP_DLY_RST  = 19'h0_0014;  // 0.100 s
    localparam logic [18:0] BF_DLY_RST      = 19'h0_0028;  // 0.200 s

    // ************************************************************
    // magnitudes and thresholds
    // ************************************************************
    localparam int          MAG_W           = 16;  // 0.001 x nominal per lsb
    localparam int          PTHR_W          = 12;  // 0.01 x nominal per lsb
    localparam logic [11:0] PTHR_MIN        = 12'h001;
    localparam logic [11:0] PTHR_MAX        = 12'hFA0;    // 40.00
    localparam logic [11:0] PTHR_RST        = 12'h064;    // 1.00
    localparam logic [15:0] RTHR_MIN        = 16'h0005;   // 0.005
    localparam logic [15:0] RTHR_MAX        = 16'h9C40;   // 40.000
    localparam logic [15:0] RTHR_RST        = 16'h04B0;   // 1.200
    localparam logic [7:0]  PTHR_SCALE      = 8'h0A;      // 0.01 to 0.001 units
    localparam logic [7:0]  HYST_NUM        = 8'h61;      // 97 percent
    localparam logic [7:0]  HYST_DEN        = 8'h64;      // 100 percent

    // ************************************************************
    // register map (byte offsets)
    // ************************************************************
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_PTHR        = 8'h04;
    localparam logic [7:0]  OFS_RTHR        = 8'h08;
    localparam logic [7:0]  OFS_RETRIP_DLY  = 8'h0C;
    localparam logic [7:0]  OFS_BF_DLY      = 8'h10;
    localparam logic [7:0]  OFS_STATUS      = 8'h14;
    localparam logic [7:0]  OFS_ELAPSED     = 8'h18;
    localparam int          CTRL_MODE_LSB   = 0;   // 4 bits
    localparam int          CTRL_RSEL_LSB   = 4;   // 2 bits
    localparam int          CTRL_RETRIP_BIT = 8;
    localparam logic [8:0]  CTRL_RST        = 9'h100;  // current only, no residual, retrip on

    // ************************************************************
    // selections and condition codes
    // ************************************************************
    typedef enum logic [1:0] {
        BFPT_RES_OFF, BFPT_RES_FIRST, BFPT_RES_SECOND, BFPT_RES_COMPUTED
    } bfpt_rsel_e;

    typedef enum logic [3:0] {
        BFPT_M_CUR, BFPT_M_DO, BFPT_M_SIG, BFPT_M_CUR_AND_DO, BFPT_M_CUR_AND_SIG,
        BFPT_M_CUR_OR_SIG, BFPT_M_SIG_AND_DO, BFPT_M_SIG_OR_DO, BFPT_M_CUR_OR_DO,
        BFPT_M_CUR_OR_SIG_OR_DO, BFPT_M_CUR_AND_DO_AND_SIG
    } bfpt_mode_e;

    typedef enum logic [2:0] {
        BFPT_C_NORMAL, BFPT_C_START, BFPT_C_RETRIP, BFPT_C_BF, BFPT_C_ON, BFPT_C_BLOCKED
    } bfpt_cond_e;
endpackage : bfpt_pkg

// >>> logic/bfpt_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - one phase threshold, any phase picks up
// - release below 97 percent of threshold
// - compare three phases and residual each cycle
// - residual source select, default disabled
// - operating mode combines current, signals, relay
// - phase threshold 0.01 steps, up to 40.00
// - residual threshold 0.001 steps, default 1.200
// - settings change live without stopping, retrip delay only while retrip on
// - sample block input at cycle start
// - pick-up while unblocked raises start, times
// - pick-up while blocked raises blocked only
// - later block clears start like release
// - both timers run from one pick-up
// - retrip enable gates retrip, default on
// - retrip after retrip delay, default 0.100s
// - failure output after delay, default 0.200s
// - readable condition status with six values
// - current mode resets timers when current drops
// - current and relay mode waits for relay
module bfpt_top #(
    parameter int CYCLE_CLKS_P = bfpt_pkg::CYCLE_CLKS
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [bfpt_pkg::MAG_W-1:0] phase_a_mag,
    input  wire logic [bfpt_pkg::MAG_W-1:0] phase_b_mag,
    input  wire logic [bfpt_pkg::MAG_W-1:0] phase_c_mag,
    input  wire logic [bfpt_pkg::MAG_W-1:0] first_residual_input,
    input  wire logic [bfpt_pkg::MAG_W-1:0] second_residual_input,
    input  wire logic [bfpt_pkg::MAG_W-1:0] computed_residual,
    input  wire logic                       signal_monitor,
    input  wire logic                       relay_monitor,
    input  wire logic                       block_in,
    output logic                            start_flag,
    output logic                            blocked_flag,
    output logic                            retrip_output,
    output logic                            breaker_failure_output,
    output logic [2:0]                      condition,
    output logic                            cycle_tick
);
    import bfpt_pkg::*;

    // ************************************************************
    // functions
    // ************************************************************
    // threshold compare with fixed 97 percent release point
    function automatic logic over_thr(input logic [MAG_W-1:0] mag,
                                      input logic [MAG_W-1:0] thr,
                                      input logic             held);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(mag) * 24'(HYST_DEN);
        rhs = 24'(thr) * 24'(HYST_NUM);
        if (held) begin
            over_thr = (lhs >= rhs);
        end else begin
            over_thr = (mag > thr);
        end
    endfunction : over_thr

    // clamp a written value into its legal range
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        if (v < lo) begin
            clamp = lo;
        end else if (v > hi) begin
            clamp = hi;
        end else begin
            clamp = v;
        end
    endfunction : clamp

    // delay reached at this tick, counting the tick now being taken
    function automatic logic dly_done(input logic [DLY_W-1:0] el,
                                      input logic [DLY_W-1:0] dly);
        dly_done = ((el + DLY_W'(1)) >= dly);
    endfunction : dly_done

    // ************************************************************
    // registers
    // ************************************************************
    // settings
    logic [3:0]        mode_r;
    logic [1:0]        rsel_r;
    logic              retrip_en_r;
    logic [PTHR_W-1:0] pthr_r;
    logic [MAG_W-1:0]  rthr_r;
    logic [DLY_W-1:0]  retrip_dly_r;
    logic [DLY_W-1:0]  bf_dly_r;
    // program-cycle state
    logic [31:0]       cyc_cnt_r;
    logic [3:0]        phase_pu_r;
    logic              block_smp_r;
    logic              pickup_r;
    logic              cur_pu_r;
    logic [DLY_W-1:0]  elapsed_r;
    // combinational terms
    logic              wr_en;
    logic              rd_setup;
    logic              mapped;
    logic [31:0]       status_word;
    logic [MAG_W-1:0]  pthr_milli;
    logic [MAG_W-1:0]  res_mag;
    logic [3:0]        phase_pu_nxt;
    logic              cur_pu_nxt;
    logic              pickup_nxt;
    logic              start_nxt;
    logic              blocked_nxt;

    // ************************************************************
    // apb slave
    // ************************************************************
    // zero wait states; unmapped addresses answer with an error
    always_comb begin
        mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_ELAPSED);
        pready = 1'b1;
        pslverr = psel && penable && !mapped;
        wr_en = psel && penable && pwrite && mapped;
        rd_setup = psel && !penable && !pwrite;
    end

    // settings writes, applied while running; retrip delay writes ignored while retrip is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r       <= CTRL_RST[CTRL_MODE_LSB +: 4];
            rsel_r       <= CTRL_RST[CTRL_RSEL_LSB +: 2];
            retrip_en_r  <= CTRL_RST[CTRL_RETRIP_BIT];
            pthr_r       <= PTHR_RST;
            rthr_r       <= RTHR_RST;
            retrip_dly_r <= RETRIP_DLY_RST;
            bf_dly_r     <= BF_DLY_RST;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTRL: begin
                    mode_r      <= pwdata[CTRL_MODE_LSB +: 4];
                    rsel_r      <= pwdata[CTRL_RSEL_LSB +: 2];
                    retrip_en_r <= pwdata[CTRL_RETRIP_BIT];
                end
                OFS_PTHR: begin
                    pthr_r <= PTHR_W'(clamp(pwdata, 32'(PTHR_MIN), 32'(PTHR_MAX)));
                end
                OFS_RTHR: begin
                    rthr_r <= MAG_W'(clamp(pwdata, 32'(RTHR_MIN), 32'(RTHR_MAX)));
                end
                OFS_RETRIP_DLY: begin
                    if (retrip_en_r) begin
                        retrip_dly_r <= DLY_W'(clamp(pwdata, 32'h0, 32'(DLY_MAX)));
                    end
                end
                OFS_BF_DLY: begin
                    bf_dly_r <= DLY_W'(clamp(pwdata, 32'h0, 32'(DLY_MAX)));
                end
                default: begin
                end
            endcase
        end
    end

    // status word: condition, pick-up and flag bits
    always_comb begin
        status_word = {24'h0, breaker_failure_output, retrip_output, blocked_flag,
                       start_flag, pickup_r, condition};
    end

    // read data captured in the setup phase, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                OFS_CTRL:       prdata <= {23'h0, retrip_en_r, 2'h0, rsel_r, mode_r};
                OFS_PTHR:       prdata <= 32'(pthr_r);
                OFS_RTHR:       prdata <= 32'(rthr_r);
                OFS_RETRIP_DLY: prdata <= 32'(retrip_dly_r);
                OFS_BF_DLY:     prdata <= 32'(bf_dly_r);
                OFS_STATUS:     prdata <= status_word;
                OFS_ELAPSED:    prdata <= 32'(elapsed_r);
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // program cycle
    // ************************************************************
    // one pulse every program cycle
    // ticks stand exactly CYCLE_CLKS_P clocks apart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt_r  <= 32'h0000_0000;
            cycle_tick <= 1'b0;
        end else if (cyc_cnt_r >= 32'(CYCLE_CLKS_P - 1)) begin
            cyc_cnt_r  <= 32'h0000_0000;
            cycle_tick <= 1'b1;
        end else begin
            cyc_cnt_r  <= cyc_cnt_r + 32'h0000_0001;
            cycle_tick <= 1'b0;
        end
    end

    // ************************************************************
    // pick-up evaluation
    // ************************************************************
    // current pick-up, residual source and operating mode for this cycle
    always_comb begin
        pthr_milli = MAG_W'(16'(pthr_r) * 16'(PTHR_SCALE));
        case (bfpt_rsel_e'(rsel_r))
            BFPT_RES_FIRST:    res_mag = first_residual_input;
            BFPT_RES_SECOND:   res_mag = second_residual_input;
            BFPT_RES_COMPUTED: res_mag = computed_residual;
            default:           res_mag = '0;
        endcase
        // shared phase threshold, residual has its own
        phase_pu_nxt[0] = over_thr(phase_a_mag, pthr_milli, phase_pu_r[0]);
        phase_pu_nxt[1] = over_thr(phase_b_mag, pthr_milli, phase_pu_r[1]);
        phase_pu_nxt[2] = over_thr(phase_c_mag, pthr_milli, phase_pu_r[2]);
        phase_pu_nxt[3] = (rsel_r != 2'(BFPT_RES_OFF))
                          && over_thr(res_mag, rthr_r, phase_pu_r[3]);
        cur_pu_nxt = |phase_pu_nxt;
        case (bfpt_mode_e'(mode_r))
            BFPT_M_DO:                 pickup_nxt = relay_monitor;
            BFPT_M_SIG:                pickup_nxt = signal_monitor;
            BFPT_M_CUR_AND_DO:         pickup_nxt = cur_pu_nxt && relay_monitor;
            BFPT_M_CUR_AND_SIG:        pickup_nxt = cur_pu_nxt && signal_monitor;
            BFPT_M_CUR_OR_SIG:         pickup_nxt = cur_pu_nxt || signal_monitor;
            BFPT_M_SIG_AND_DO:         pickup_nxt = signal_monitor && relay_monitor;
            BFPT_M_SIG_OR_DO:          pickup_nxt = signal_monitor || relay_monitor;
            BFPT_M_CUR_OR_DO:          pickup_nxt = cur_pu_nxt || relay_monitor;
            BFPT_M_CUR_OR_SIG_OR_DO:   pickup_nxt = cur_pu_nxt || signal_monitor
                                                    || relay_monitor;
            BFPT_M_CUR_AND_DO_AND_SIG: pickup_nxt = cur_pu_nxt && relay_monitor
                                                    && signal_monitor;
            default:                   pickup_nxt = cur_pu_nxt;
        endcase
        // block decision uses block_in as it stands at the tick, or the held blocked flag
        if (!pickup_nxt) begin
            start_nxt   = 1'b0;
            blocked_nxt = 1'b0;
        end else if (block_in || blocked_flag) begin
            start_nxt   = 1'b0;
            blocked_nxt = 1'b1;
        end else begin
            start_nxt   = 1'b1;
            blocked_nxt = 1'b0;
        end
    end

    // block input sampled first in every program cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_smp_r <= 1'b0;
        end else if (cycle_tick) begin
            block_smp_r <= block_in;
        end
    end

    // pick-up and flag state, updated once per program cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_pu_r   <= 4'h0;
            cur_pu_r     <= 1'b0;
            pickup_r     <= 1'b0;
            start_flag   <= 1'b0;
            blocked_flag <= 1'b0;
        end else if (cycle_tick) begin
            phase_pu_r   <= phase_pu_nxt;
            cur_pu_r     <= cur_pu_nxt;
            pickup_r     <= pickup_nxt;
            start_flag   <= start_nxt;
            blocked_flag <= blocked_nxt;
        end
    end

    // ************************************************************
    // delay timers
    // ************************************************************
    // one elapsed count serves both delays from the same start
    // it saturates at the longest delay so it never wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elapsed_r <= '0;
        end else if (cycle_tick) begin
            if (!start_nxt) begin
                elapsed_r <= '0;
            end else if (start_flag && elapsed_r != DLY_MAX) begin
                elapsed_r <= elapsed_r + DLY_W'(1);
            end
        end
    end

    // trip-class outputs held while start persists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retrip_output          <= 1'b0;
            breaker_failure_output <= 1'b0;
        end else if (cycle_tick) begin
            retrip_output          <= start_nxt && start_flag && retrip_en_r
                                      && dly_done(elapsed_r, retrip_dly_r);
            breaker_failure_output <= start_nxt && start_flag
                                      && dly_done(elapsed_r, bf_dly_r);
        end
    end

    // ************************************************************
    // condition status
    // ************************************************************
    // condition follows the flags one clock later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            condition <= 3'(BFPT_C_NORMAL);
        end else begin
            if (breaker_failure_output) begin
                condition <= 3'(BFPT_C_BF);
            end else if (retrip_output) begin
                condition <= 3'(BFPT_C_RETRIP);
            end else if (start_flag) begin
                condition <= 3'(BFPT_C_START);
            end else if (blocked_flag) begin
                condition <= 3'(BFPT_C_BLOCKED);
            end else if (cur_pu_r || block_smp_r) begin
                condition <= 3'(BFPT_C_ON);
            end else begin
                condition <= 3'(BFPT_C_NORMAL);
            end
        end
    end
endmodule : bfpt_top
`default_nettype wire

// >>> sim/bfpt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// pick-up, block and output checker
// ************************************************************
module bfpt_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       block_in,
    input wire logic       cycle_tick,
    input wire logic       start_flag,
    input wire logic       blocked_flag,
    input wire logic       retrip_output,
    input wire logic       breaker_failure_output,
    input wire logic [2:0] condition
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // block input seen at a program cycle edge
    sequence blk_tick;
        cycle_tick && block_in;
    endsequence
    // flags only move at a program cycle edge
    tick_update_a: assert property (
        !$past(cycle_tick) |-> $stable(start_flag) && $stable(blocked_flag))
        else $error("flag moved between cycles");
    start_block_a: assert property (blk_tick |=> !start_flag)
        else $error("start while blocked");
    flag_excl_a: assert property (!(start_flag && blocked_flag))
        else $error("start and blocked together");
    blk_quiet_a: assert property (
        blocked_flag |-> !retrip_output && !breaker_failure_output)
        else $error("output while blocked");
    retrip_start_a: assert property (retrip_output |-> start_flag)
        else $error("retrip without start");
    bf_start_a: assert property (breaker_failure_output |-> start_flag)
        else $error("failure output without start");
    no_early_a: assert property (
        $rose(start_flag) |-> !retrip_output && !breaker_failure_output)
        else $error("output in pick-up cycle");
    outs_drop_a: assert property (
        $fell(start_flag) |-> !retrip_output && !breaker_failure_output)
        else $error("output kept after release");
    cond_bf_a: assert property (breaker_failure_output |=> condition == 3'h3)
        else $error("condition not failure");
    cond_blk_a: assert property (blocked_flag |=> condition == 3'h5)
        else $error("condition not blocked");
endmodule : bfpt_monitor

bind bfpt_top bfpt_monitor u_mon (.pclk, .presetn, .block_in, .cycle_tick, .start_flag,
    .blocked_flag, .retrip_output, .breaker_failure_output, .condition);
`default_nettype wire

// >>> sim/bfpt_field.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// field side: feeders, relay contact, blocking matrix
// ************************************************************
module bfpt_field (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] lvl,
    input  wire logic [2:0]  chan,
    input  wire logic [2:0]  req,
    output logic      [15:0] mag [6],
    output logic             sig,
    output logic             relay,
    output logic             blk
);
    // only the faulted channel carries current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mag <= '{default: 16'h0000};
            {sig, relay, blk} <= 3'b000;
        end else begin
            for (int i = 0; i < 6; i++) begin
                mag[i] <= (chan == 3'(i)) ? lvl : 16'h0000;
            end
            {sig, relay, blk} <= req; // block lands one clock after the request, in the same clock as the currents
        end
    end
endmodule : bfpt_field
`default_nettype wire

// >>> sim/bfpt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench
// ************************************************************
module bfpt_top_tb;
    import bfpt_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, sig, relay, blk, cycle_tick;
    logic        start_flag, blocked_flag, retrip_output, breaker_failure_output;
    logic [2:0]  condition;
    logic [15:0] lvl = 16'h0000;
    logic [2:0]  chan = 3'h0;
    logic [2:0]  req = 3'b000;
    logic [15:0] mag [6];
    logic [10:0] mask [3] = '{11'h321, 11'h3E6, 11'h7FF};
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    bfpt_top #(.CYCLE_CLKS_P(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .phase_a_mag(mag[0]), .phase_b_mag(mag[1]),
        .phase_c_mag(mag[2]), .first_residual_input(mag[3]), .second_residual_input(mag[4]),
        .computed_residual(mag[5]), .signal_monitor(sig), .relay_monitor(relay),
        .block_in(blk), .start_flag, .blocked_flag, .retrip_output,
        .breaker_failure_output, .condition, .cycle_tick);
    bfpt_field u_field (.pclk, .presetn, .lvl, .chan, .req, .mag, .sig, .relay, .blk);

    // clock and hang limit
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), rd, e);
    endtask : rdc

    // wait for n program cycle edges, then let their updates land
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            while (cycle_tick !== 1'b1) @(posedge pclk);
        end
        #1;
    endtask : ticks

    task automatic drv(input logic [15:0] l, input logic [2:0] c, input logic [2:0] r);
        @(posedge pclk);
        lvl <= l;
        chan <= c;
        req <= r;
    endtask : drv

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFS_CTRL, 32'h0000_0100);
        rdc(OFS_RTHR, 32'h0000_04B0);
        rdc(OFS_RETRIP_DLY, 32'h0000_0014);
        rdc(OFS_BF_DLY, 32'h0000_0028);
        rdc(OFS_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped", 32'(er), 32'h0000_0001);
        apb(1'b1, OFS_PTHR, 32'h0000_0FA1);
        rdc(OFS_PTHR, 32'h0000_0FA0);
        apb(1'b1, OFS_PTHR, 32'h0000_03E8);
        apb(1'b1, OFS_RETRIP_DLY, 32'h0000_0003);
        apb(1'b1, OFS_BF_DLY, 32'h0000_0006);
        drv(16'hFFFF, 3'h3, 3'b000);
        ticks(3);
        chk("res off", 32'(start_flag), 32'h0000_0000);
        for (int r = 1; r < 4; r++) begin
            apb(1'b1, OFS_CTRL, 32'h0000_0100 | 32'(r << 4));
            drv(16'h04B1, 3'(r + 2), 3'b000);
            ticks(3);
            chk("res on", 32'(start_flag), 32'h0000_0001);
            drv(16'h0000, 3'h0, 3'b000);
            ticks(3);
        end
        apb(1'b1, OFS_CTRL, 32'h0000_0100);
        drv(16'h2711, 3'h1, 3'b000);
        for (int i = 0; i < 4; i++) if (start_flag !== 1'b1) ticks(1);
        chk("start", 32'(start_flag), 32'h0000_0001);
        ticks(2);
        chk("retrip early", 32'(retrip_output), 32'h0000_0000);
        ticks(1);
        chk("retrip", 32'(retrip_output), 32'h0000_0001);
        ticks(2);
        chk("bf early", 32'(breaker_failure_output), 32'h0000_0000);
        ticks(1);
        chk("bf", 32'(breaker_failure_output), 32'h0000_0001);
        drv(16'h25E4, 3'h1, 3'b000);
        ticks(3);
        chk("hysteresis", 32'(start_flag), 32'h0000_0001);
        apb(1'b1, OFS_PTHR, 32'h0000_044C);
        ticks(2);
        chk("live release", 32'({start_flag, retrip_output}), 32'h0000_0000);
        rdc(OFS_ELAPSED, 32'h0000_0000);
        apb(1'b1, OFS_PTHR, 32'h0000_03E8);
        drv(16'h2711, 3'h0, 3'b001);
        ticks(3);
        chk("blocked", 32'({blocked_flag, start_flag}), 32'h0000_0002);
        drv(16'h0000, 3'h0, 3'b000);
        ticks(3);
        drv(16'h2711, 3'h0, 3'b000);
        ticks(3);
        chk("pre block", 32'(start_flag), 32'h0000_0001);
        drv(16'h2711, 3'h0, 3'b001);
        ticks(2);
        chk("late block", 32'({start_flag, retrip_output}), 32'h0000_0000);
        drv(16'h0000, 3'h0, 3'b000);
        ticks(3);
        apb(1'b1, OFS_CTRL, 32'h0000_0103);
        drv(16'h2711, 3'h0, 3'b000);
        ticks(3);
        chk("wait relay", 32'({start_flag, condition}), 32'h0000_0004);
        drv(16'h2711, 3'h0, 3'b010);
        ticks(3);
        chk("relay go", 32'(start_flag), 32'h0000_0001);
        for (int m = 0; m < 11; m++) begin
            for (int s = 0; s < 3; s++) begin
                drv(16'h0000, 3'h0, 3'b000);
                ticks(2);
                apb(1'b1, OFS_CTRL, 32'h0000_0100 | 32'(m));
                drv((s == 1) ? 16'h0000 : 16'h2711, 3'h0, (s == 0) ? 3'b000 : 3'b110);
                ticks(2);
                chk("mode", 32'(start_flag), 32'(mask[s][m]));
            end
        end
        drv(16'h0000, 3'h0, 3'b000);
        ticks(2);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b1, OFS_RETRIP_DLY, 32'h0000_0001);
        rdc(OFS_RETRIP_DLY, 32'h0000_0003);
        drv(16'h2711, 3'h2, 3'b000);
        ticks(9);
        chk("no retrip", 32'({retrip_output, breaker_failure_output}), 32'h1);
        give_verdict();
    end
endmodule : bfpt_top_tb
`default_nettype wire
